/* rtl/dts_select.sv */
// Termination selector: picks off, write, nominal or park each cycle.
// Assumes latencies and mode fields are held stable by mode registers.
`timescale 1ns/10ps
module dts_select (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic odt_pin,
	input wire logic cmd_write,
	input wire logic cmd_read,
	input wire logic self_refresh,
	input wire logic cfg_x16,
	input wire logic strobe_pin_en,
	input wire logic [2:0] nom_field,
	input wire logic [2:0] wr_field,
	input wire logic [2:0] park_field,
	input wire logic preamble_2,
	input wire logic crc_en,
	input wire logic burst_bc4,
	input wire logic [5:0] read_lat,
	input wire logic [5:0] write_lat,
	input wire logic [5:0] odt_lat,
	output logic [1:0] term_sel,
	output logic [2:0] term_value,
	output logic term_lower_en,
	output logic term_upper_en,
	output logic term_strobe_en,
	output logic odt_rx_en
);
	logic odt_s1_q, odt_s2_q;
	logic [63:0] odt_hist_q, wr_hist_q, rd_hist_q;
	logic [5:0] wr_cnt_q, rd_cnt_q;
	logic nom_en, wr_en, park_en, odt_live;
	logic [5:0] pre_ofs, nom_tap, wr_tap, rd_tap, rd_len, wr_len, half_bl;
	logic nom_on, wr_start, rd_start;
	logic [1:0] sel_d;

	// Safe subtraction of a latency offset, floored at one.
	function automatic logic [5:0] lat_tap(logic [5:0] lat, logic [5:0] ofs);
		lat_tap = (lat > ofs) ? 6'(lat - ofs) : 6'h01;
	endfunction

	assign nom_en = nom_field != dts_pkg::DTS_FIELD_OFF;
	assign wr_en = wr_field != dts_pkg::DTS_FIELD_OFF;
	assign park_en = park_field != dts_pkg::DTS_FIELD_OFF;
	assign odt_live = odt_s2_q & nom_en & ~self_refresh;
	assign pre_ofs = preamble_2 ? dts_pkg::DTS_PRE2_OFS : dts_pkg::DTS_PRE1_OFS;
	assign nom_tap = lat_tap(odt_lat, pre_ofs);
	assign wr_tap = lat_tap(write_lat, dts_pkg::DTS_WR_OFS);
	assign rd_tap = lat_tap(read_lat, pre_ofs);
	assign half_bl = burst_bc4 ? dts_pkg::DTS_HALF_BC4 : dts_pkg::DTS_HALF_BL8;
	assign rd_len = 6'(half_bl + pre_ofs + {5'h00, crc_en});
	assign wr_len = 6'(half_bl + {5'h00, preamble_2} + {5'h00, crc_en}
		+ dts_pkg::DTS_WR_TAIL);
	assign nom_on = odt_hist_q[nom_tap];
	assign wr_start = wr_hist_q[wr_tap] & wr_en;
	assign rd_start = rd_hist_q[rd_tap];

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			odt_s1_q <= 1'b0;
			odt_s2_q <= 1'b0;
		end else begin
			odt_s1_q <= odt_pin;
			odt_s2_q <= odt_s1_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			odt_hist_q <= '0;
			wr_hist_q <= '0;
			rd_hist_q <= '0;
		end else begin
			odt_hist_q <= {odt_hist_q[62:0], odt_live};
			wr_hist_q <= {wr_hist_q[62:0], cmd_write & ~self_refresh};
			rd_hist_q <= {rd_hist_q[62:0], cmd_read & ~self_refresh};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			wr_cnt_q <= '0;
		else if (wr_start)
			wr_cnt_q <= wr_len;
		else if (wr_cnt_q != 6'h00)
			wr_cnt_q <= 6'(wr_cnt_q - 6'h01);
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			rd_cnt_q <= '0;
		else if (rd_start)
			rd_cnt_q <= 6'(rd_len - 6'h01);
		else if (rd_cnt_q != 6'h00)
			rd_cnt_q <= 6'(rd_cnt_q - 6'h01);
	end

	always_comb begin
		if (self_refresh || rd_start || rd_cnt_q != 6'h00)
			sel_d = dts_pkg::DTS_SEL_OFF;
		else if (wr_start || wr_cnt_q != 6'h00)
			sel_d = dts_pkg::DTS_SEL_WR;
		else if (nom_on && nom_en)
			sel_d = dts_pkg::DTS_SEL_NOM;
		else if (park_en)
			sel_d = dts_pkg::DTS_SEL_PARK;
		else
			sel_d = dts_pkg::DTS_SEL_OFF;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			term_sel <= dts_pkg::DTS_SEL_OFF;
			term_value <= dts_pkg::DTS_FIELD_OFF;
		end else begin
			term_sel <= sel_d;
			unique case (sel_d)
				dts_pkg::DTS_SEL_WR: term_value <= wr_field;
				dts_pkg::DTS_SEL_NOM: term_value <= nom_field;
				dts_pkg::DTS_SEL_PARK: term_value <= park_field;
				dts_pkg::DTS_SEL_OFF: term_value <= dts_pkg::DTS_FIELD_OFF;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			term_lower_en <= 1'b0;
			term_upper_en <= 1'b0;
			term_strobe_en <= 1'b0;
			odt_rx_en <= 1'b0;
		end else begin
			term_lower_en <= sel_d != dts_pkg::DTS_SEL_OFF;
			term_upper_en <= cfg_x16 && sel_d != dts_pkg::DTS_SEL_OFF;
			term_strobe_en <= !cfg_x16 && strobe_pin_en
				&& sel_d != dts_pkg::DTS_SEL_OFF;
			odt_rx_en <= nom_en && !self_refresh;
		end
	end

	// Termination is off.
	sequence dts_off_s;
		term_sel == dts_pkg::DTS_SEL_OFF;
	endsequence
	// A read reaches its start tap.
	sequence dts_rd_launch_s;
		rd_start;
	endsequence
	// A write reaches its tap with no read or self refresh in the way.
	sequence dts_wr_launch_s;
		wr_start && !self_refresh && rd_cnt_q == 6'h00 && !rd_start;
	endsequence
	// Write termination is selected.
	sequence dts_wr_on_s;
		term_sel == dts_pkg::DTS_SEL_WR;
	endsequence

	chk_srf_term_off: assert property (
		@(posedge clk_sys) disable iff (reset)
		self_refresh |=> dts_off_s)
		else $error("termination on in self refresh");
	chk_read_hiz: assert property (
		@(posedge clk_sys) disable iff (reset)
		rd_cnt_q != 6'h00 |=> dts_off_s)
		else $error("termination on during read window");
	chk_read_start: assert property (
		@(posedge clk_sys) disable iff (reset)
		dts_rd_launch_s |=> dts_off_s)
		else $error("termination on at read start");
	chk_read_len: assert property (
		@(posedge clk_sys) disable iff (reset)
		rd_start |=> rd_cnt_q == 6'($past(rd_len) - 6'h01))
		else $error("read window length wrong");
	chk_rx_power: assert property (
		@(posedge clk_sys) disable iff (reset)
		!nom_en |=> !odt_rx_en)
		else $error("receiver powered with nominal off");
	chk_park_default: assert property (
		@(posedge clk_sys) disable iff (reset)
		sel_d == dts_pkg::DTS_SEL_PARK |=> term_value == $past(park_field))
		else $error("park value wrong");
	chk_write_win: assert property (
		@(posedge clk_sys) disable iff (reset)
		dts_wr_launch_s |=> dts_wr_on_s)
		else $error("write termination missing");
	chk_write_len: assert property (
		@(posedge clk_sys) disable iff (reset)
		wr_start |=> wr_cnt_q == $past(wr_len))
		else $error("write window length wrong");
	chk_upper_lane: assert property (
		@(posedge clk_sys) disable iff (reset)
		term_upper_en |-> term_lower_en)
		else $error("upper lane without lower");
	chk_strobe_x8: assert property (
		@(posedge clk_sys) disable iff (reset)
		cfg_x16 || !strobe_pin_en |=> !term_strobe_en)
		else $error("strobe pin terminated when not allowed");
	chk_off_value: assert property (
		@(posedge clk_sys) disable iff (reset)
		term_sel == dts_pkg::DTS_SEL_OFF |-> term_value == 3'h0)
		else $error("value present while termination off");
	chk_nom_gate: assert property (
		@(posedge clk_sys) disable iff (reset)
		!nom_en |=> term_sel != dts_pkg::DTS_SEL_NOM)
		else $error("nominal selected while disabled");
endmodule

/* rtl/dts_pkg.sv */
// Constants for the DRAM termination selector.
// Assumes a single command clock; mode fields arrive as static ports.
// Notes on behaviour
// - x8: all pins, strobe pin if enabled
// - x16: both byte lanes terminated
// - Self refresh: termination off, pin ignored
// - Nominal field zero: ODT pin ignored
// - Enabled if any field non-zero
// - WRITE gives write termination for window
// - ODT high turns on nominal termination
// - Park applies when nominal is off
// - Priority: disable, write, nominal, park
// - READ window forces high impedance
// - Nominal disabled powers down ODT receiver
// - Read off starts RL-2 or RL-3
// - Off lasts BL/2+2/3, +1 with CRC
// - Nominal on after CWL+AL+PL-2/3
// - Write termination after WL-2
package dts_pkg;
	localparam int DTS_LAT_W = 6;
	localparam int DTS_DLY_DEPTH = 64;
	localparam logic [2:0] DTS_FIELD_OFF = 3'h0;
	localparam logic [5:0] DTS_PRE1_OFS = 6'h02;
	localparam logic [5:0] DTS_PRE2_OFS = 6'h03;
	localparam logic [5:0] DTS_WR_OFS = 6'h02;
	localparam logic [5:0] DTS_WR_EXTRA = 6'h04;
	localparam logic [5:0] DTS_HALF_BC4 = 6'h02;
	localparam logic [5:0] DTS_HALF_BL8 = 6'h04;
	localparam logic [5:0] DTS_WR_TAIL = 6'h01;
	localparam logic [1:0] DTS_SEL_OFF = 2'h0;
	localparam logic [1:0] DTS_SEL_WR = 2'h1;
	localparam logic [1:0] DTS_SEL_NOM = 2'h2;
	localparam logic [1:0] DTS_SEL_PARK = 2'h3;
endpackage

/* dv/dts_ctrl_model.sv */
// Controller model: registers bench requests into ODT and commands.
// Assumes the bench requests at rising edges of clk_sys.
`timescale 1ns/10ps
module dts_ctrl_model (
	input wire logic clk_sys,
	input wire logic rd_req,
	input wire logic wr_req,
	input wire logic odt_req,
	output logic cmd_read,
	output logic cmd_write,
	output logic odt_pin
);
	// Read inversion is never enabled, so no mask mode is needed.
	always_ff @(posedge clk_sys) begin
		cmd_read <= rd_req;
		cmd_write <= wr_req;
		odt_pin <= odt_req;
	end
endmodule

/* dv/dts_select_tb_top.sv */
// Testbench for the termination selector.
// Assumes a controller model drives ODT and commands.
`timescale 1ns/10ps
module dts_select_tb_top;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic rd_req = 1'b0, wr_req = 1'b0, odt_req = 1'b0;
	logic cmd_read, cmd_write, odt_pin;
	logic self_refresh = 1'b0, cfg_x16 = 1'b0, strobe_pin_en = 1'b1;
	logic preamble_2 = 1'b0, crc_en = 1'b0, burst_bc4 = 1'b0;
	logic [2:0] nom_field = 3'h0, wr_field = 3'h0, park_field = 3'h5;
	logic [5:0] read_lat = 6'h0a, write_lat = 6'h09, odt_lat = 6'h08;
	logic [1:0] term_sel;
	logic [2:0] term_value;
	logic lo, up, st, rx;
	int fail_count = 0;
	int compares = 0;
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	dts_ctrl_model ctrl (.clk_sys(clk_sys), .rd_req(rd_req),
		.wr_req(wr_req), .odt_req(odt_req), .cmd_read(cmd_read),
		.cmd_write(cmd_write), .odt_pin(odt_pin));
	dts_select DUT (.clk_sys(clk_sys), .reset(reset), .odt_pin(odt_pin),
		.cmd_write(cmd_write), .cmd_read(cmd_read),
		.self_refresh(self_refresh), .cfg_x16(cfg_x16),
		.strobe_pin_en(strobe_pin_en), .nom_field(nom_field),
		.wr_field(wr_field), .park_field(park_field),
		.preamble_2(preamble_2), .crc_en(crc_en), .burst_bc4(burst_bc4),
		.read_lat(read_lat), .write_lat(write_lat), .odt_lat(odt_lat),
		.term_sel(term_sel), .term_value(term_value), .term_lower_en(lo),
		.term_upper_en(up), .term_strobe_en(st), .odt_rx_en(rx));
	task automatic check(input logic [2:0] seen, input logic [2:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic sel(input logic [1:0] s, input logic [2:0] v);
		check({1'b0, term_sel}, {1'b0, s});
		check(term_value, v);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic pulse(input bit rd);
		@(posedge clk_sys);
		if (rd) begin
			rd_req <= 1'b1;
		end else begin
			wr_req <= 1'b1;
		end
		@(posedge clk_sys);
		rd_req <= 1'b0;
		wr_req <= 1'b0;
	endtask
	task automatic stop_test;
		$display("compares=%0d fail_count=%0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		tick(16);
		@(posedge clk_sys);
		reset <= 1'b0;
		tick(3);
		sel(dts_pkg::DTS_SEL_PARK, 3'h5);
		check({2'h0, rx}, 3'h0);
		check({lo, up, st}, 3'h5);
		@(posedge clk_sys);
		strobe_pin_en <= 1'b0;
		tick(2);
		check({lo, up, st}, 3'h4);
		@(posedge clk_sys);
		cfg_x16 <= 1'b1;
		nom_field <= 3'h2;
		wr_field <= 3'h1;
		odt_req <= 1'b1;
		tick(10);
		sel(dts_pkg::DTS_SEL_PARK, 3'h5);
		tick(1);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		check({lo, up, st}, 3'h6);
		check({2'h0, rx}, 3'h1);
		pulse(1'b0);
		tick(8);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		tick(1);
		sel(dts_pkg::DTS_SEL_WR, 3'h1);
		tick(5);
		sel(dts_pkg::DTS_SEL_WR, 3'h1);
		tick(1);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		pulse(1'b1);
		tick(9);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		tick(1);
		sel(dts_pkg::DTS_SEL_OFF, 3'h0);
		tick(5);
		sel(dts_pkg::DTS_SEL_OFF, 3'h0);
		tick(1);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		@(posedge clk_sys);
		preamble_2 <= 1'b1;
		crc_en <= 1'b1;
		pulse(1'b1);
		tick(8);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		tick(1);
		sel(dts_pkg::DTS_SEL_OFF, 3'h0);
		tick(7);
		sel(dts_pkg::DTS_SEL_OFF, 3'h0);
		tick(1);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		@(posedge clk_sys);
		burst_bc4 <= 1'b1;
		pulse(1'b0);
		tick(8);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		tick(1);
		sel(dts_pkg::DTS_SEL_WR, 3'h1);
		tick(5);
		sel(dts_pkg::DTS_SEL_WR, 3'h1);
		tick(1);
		sel(dts_pkg::DTS_SEL_NOM, 3'h2);
		@(posedge clk_sys);
		self_refresh <= 1'b1;
		tick(3);
		sel(dts_pkg::DTS_SEL_OFF, 3'h0);
		check({2'h0, rx}, 3'h0);
		check({lo, up, st}, 3'h0);
		@(posedge clk_sys);
		self_refresh <= 1'b0;
		nom_field <= 3'h0;
		tick(3);
		sel(dts_pkg::DTS_SEL_PARK, 3'h5);
		@(posedge clk_sys);
		park_field <= 3'h0;
		wr_field <= 3'h0;
		tick(3);
		sel(dts_pkg::DTS_SEL_OFF, 3'h0);
		stop_test;
	end
endmodule
